/* design/ssp_consts.vh */
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH
// register byte addresses
`define SSP_ADDR_CTRL 8'h14
`define SSP_ADDR_BUF 8'h18
`define SSP_ADDR_STAT 8'h1C
// control register fields
`define SSP_CTRL_RESET 8'h00
`define SSP_BIT_WRITE_COLLISION_FLAG 7
`define SSP_BIT_OVF 6
`define SSP_BIT_EN 5
`define SSP_BIT_CKP 4
`define SSP_MODE_HI 3
`define SSP_MODE_LO 0
// mode codes
`define SSP_M_SPI_M0 4'h0
`define SSP_M_SPI_M1 4'h1
`define SSP_M_SPI_M2 4'h2
`define SSP_M_SPI_MT2 4'h3
`define SSP_M_SPI_S_SEL 4'h4
`define SSP_M_SPI_S_NOSEL 4'h5
`define SSP_M_I2C_S7 4'h6
`define SSP_M_I2C_S10 4'h7
`define SSP_M_I2C_FW 4'hB
`define SSP_M_I2C_I7 4'hE
`define SSP_M_I2C_I10 4'hF
// clock divisors (half periods in clock_i cycles)
`define SSP_DIV0 8'h01
`define SSP_DIV1 8'h04
`define SSP_DIV2 8'h10
`define SSP_DIV3 8'h20
`define SSP_BITS 4'h8
`define SSP_DIV_LAST 8'h01
// axi responses
`define SSP_RESP_OKAY 2'b00
`define SSP_RESP_SLVERR 2'b10
`endif

/* design/ssp_sync2.v */
`timescale 1ns/1ps
// two flip-flop synchroniser for pin inputs
module ssp_sync2 #(
  parameter W = 3
) (
  input wire clock_i,
  input wire nrst_i,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  // first stage read only by second stage
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
    end
  end
  assign q_o = s2_reg;
endmodule // ssp_sync2

/* design/ssp_port.v */
`timescale 1ns/1ps
`include "ssp_consts.vh"
module ssp_port (
  input wire clock_i,
  input wire nrst_i,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire sck_pin_i,
  output wire sck_pin_o,
  output wire sck_pin_oe_o,
  input wire sdi_pin_i,
  output wire sdo_pin_o,
  output wire sdo_pin_oe_o,
  input wire sel_n_pin_i,
  output wire port_owns_pins_o,
  output wire i2c_mode_o,
  output wire i2c_transmit_i_unused_o
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  reg [7:0] serial_port_control_reg;
  reg [7:0] transfer_buffer_reg;
  reg [7:0] serial_shift_register_reg;
  reg buf_full_reg;
  reg busy_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] div_cnt_reg;
  reg sck_reg;
  reg sdo_reg;
  reg sck_prev_reg;
  reg aw_got_reg;
  reg w_got_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  wire [2:0] pins_sync;
  wire sck_s;
  wire sdi_s;
  wire sel_n_s;
  wire [3:0] mode;
  wire enabled;
  wire clock_polarity_hold;

  ssp_sync2 #(.W(3)) u_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .d_i({sck_pin_i, sdi_pin_i, sel_n_pin_i}),
    .q_o(pins_sync)
  );
  assign sck_s = pins_sync[2];
  assign sdi_s = pins_sync[1];
  assign sel_n_s = pins_sync[0];

  assign mode = serial_port_control_reg[`SSP_MODE_HI:`SSP_MODE_LO];
  assign enabled = serial_port_control_reg[`SSP_BIT_EN];
  assign clock_polarity_hold = serial_port_control_reg[`SSP_BIT_CKP];

  ////////////////////////////////////////////////////////////////////////////
  // mode decoding
  function is_spi_master;
    input [3:0] m;
    begin
      is_spi_master = (m[3:2] == 2'b00);
    end
  endfunction

  function is_spi_slave;
    input [3:0] m;
    begin
      is_spi_slave = (m == `SSP_M_SPI_S_SEL) || (m == `SSP_M_SPI_S_NOSEL);
    end
  endfunction

  function is_i2c_slave;
    input [3:0] m;
    begin
      is_i2c_slave = (m == `SSP_M_I2C_S7) || (m == `SSP_M_I2C_S10);
    end
  endfunction

  function is_i2c;
    input [3:0] m;
    begin
      is_i2c = is_i2c_slave(m) || (m == `SSP_M_I2C_FW) || (m == `SSP_M_I2C_I7) ||
        (m == `SSP_M_I2C_I10);
    end
  endfunction

  function [7:0] half_period;
    input [3:0] m;
    begin
      case (m[1:0])
        2'b00: half_period = `SSP_DIV0;
        2'b01: half_period = `SSP_DIV1;
        2'b10: half_period = `SSP_DIV2;
        default: half_period = `SSP_DIV3;
      endcase
    end
  endfunction

  wire spi_m = enabled && is_spi_master(mode);
  wire spi_s = enabled && is_spi_slave(mode);
  // select high in select-controlled slave mode holds the engine in reset
  wire sel_reset = spi_s && (mode == `SSP_M_SPI_S_SEL) && sel_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // bus handshakes
  wire wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_got_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire rd_fire = s_axi_arvalid && !s_axi_rvalid;
  wire wr_ctrl = wr_fire && (aw_addr_reg == `SSP_ADDR_CTRL) && w_strb_reg[0];
  wire wr_buf = wr_fire && (aw_addr_reg == `SSP_ADDR_BUF) && w_strb_reg[0];
  wire rd_buf = rd_fire && (s_axi_araddr == `SSP_ADDR_BUF);

  // engine events
  wire sck_idle = clock_polarity_hold;
  wire slave_edge = spi_s && !sel_reset && (sck_s != sck_prev_reg);
  wire slave_sample = slave_edge && (sck_s != sck_idle);
  wire slave_shift = slave_edge && (sck_s == sck_idle);
  wire master_tick = spi_m && busy_reg && (div_cnt_reg == `SSP_DIV_LAST);
  wire master_sample = master_tick && (sck_reg == sck_idle);
  wire master_shift = master_tick && (sck_reg != sck_idle);
  wire sample = master_sample || slave_sample;
  wire byte_done = sample && (bit_cnt_reg == `SSP_BITS - 4'h1);
  wire [7:0] rx_byte = {serial_shift_register_reg[6:0], sdi_s};
  wire i2c_tx = 1'b0; // i2c shifting not present; flag ignored while transmitting
  wire ovf_event = byte_done && buf_full_reg && !spi_m && !i2c_tx;
  wire write_collision_flag_event = wr_buf && busy_reg && spi_s;

  ////////////////////////////////////////////////////////////////////////////
  // bus write path and response
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SSP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg == `SSP_ADDR_CTRL || aw_addr_reg == `SSP_ADDR_BUF ||
          aw_addr_reg == `SSP_ADDR_STAT) ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SSP_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SSP_RESP_OKAY;
      case (s_axi_araddr)
        `SSP_ADDR_CTRL: s_axi_rdata <= {24'h00_0000, serial_port_control_reg};
        `SSP_ADDR_BUF: s_axi_rdata <= {24'h00_0000, transfer_buffer_reg};
        `SSP_ADDR_STAT: s_axi_rdata <= {30'h0, busy_reg, buf_full_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `SSP_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register; hardware sets win over software clears
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      serial_port_control_reg <= `SSP_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        serial_port_control_reg <= w_data_reg[7:0];
      end
      if (write_collision_flag_event) begin
        serial_port_control_reg[`SSP_BIT_WRITE_COLLISION_FLAG] <= 1'b1;
      end
      if (ovf_event) begin
        serial_port_control_reg[`SSP_BIT_OVF] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift engine
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      transfer_buffer_reg <= 8'h00;
      serial_shift_register_reg <= 8'h00;
      buf_full_reg <= 1'b0;
      busy_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      div_cnt_reg <= 8'h00;
      sck_reg <= 1'b0;
      sdo_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= sck_s;
      if (rd_buf) begin
        buf_full_reg <= 1'b0;
      end
      if (!enabled || sel_reset) begin
        busy_reg <= 1'b0;
        bit_cnt_reg <= 4'h0;
        sck_reg <= clock_polarity_hold;
        div_cnt_reg <= 8'h00;
      end else begin
        if (wr_buf && !busy_reg) begin
          // load transmit byte; master starts clocking
          serial_shift_register_reg <= w_data_reg[7:0];
          sdo_reg <= w_data_reg[7];
          busy_reg <= 1'b1;
          bit_cnt_reg <= 4'h0;
          div_cnt_reg <= half_period(mode);
        end
        if (spi_m && !busy_reg) begin
          sck_reg <= clock_polarity_hold;
        end
        if (master_tick) begin
          sck_reg <= !sck_reg;
          div_cnt_reg <= half_period(mode);
        end else if (spi_m && busy_reg && div_cnt_reg != 8'h00) begin
          div_cnt_reg <= div_cnt_reg - 8'h01;
        end
        if (sample) begin
          serial_shift_register_reg <= rx_byte;
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (byte_done) begin
            busy_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            if (!ovf_event) begin
              transfer_buffer_reg <= rx_byte;
              buf_full_reg <= 1'b1;
            end
          end
        end
        if (master_shift || slave_shift) begin
          sdo_reg <= serial_shift_register_reg[7];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin muxing
  assign port_owns_pins_o = enabled;
  assign i2c_mode_o = enabled && is_i2c(mode);
  assign i2c_transmit_i_unused_o = enabled && is_i2c_slave(mode) && !clock_polarity_hold;
  assign sck_pin_o = sck_reg;
  assign sck_pin_oe_o = spi_m;
  assign sdo_pin_o = sdo_reg;
  assign sdo_pin_oe_o = spi_m || (spi_s && !sel_reset);
endmodule // ssp_port

/* tb/ssp_port_properties.sv */
`timescale 1ns/1ps
// bus and pin checks on the port
module ssp_port_properties (
  input wire clock_i,
  input wire nrst_i,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire sck_pin_oe_o,
  input wire sdo_pin_oe_o,
  input wire port_owns_pins_o,
  input wire i2c_mode_o,
  input wire i2c_transmit_i_unused_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // address and data taken together
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_soon;
    ##[1:4] s_axi_bvalid;
  endsequence
  write_resp_a: assert property (wr_taken |-> resp_soon) else $error("no write answer");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid) else $error("no read answer");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  pins_free_a: assert property (!port_owns_pins_o |-> !(sck_pin_oe_o || sdo_pin_oe_o || i2c_mode_o))
    else $error("pins driven while off");
  enable_write_a: assert property ($changed(port_owns_pins_o) |-> ##[0:2] s_axi_bvalid)
    else $error("enable moved alone");
  i2c_pins_a: assert property (i2c_mode_o |-> !sck_pin_oe_o && !sdo_pin_oe_o)
    else $error("spi pins in i2c mode");
  hold_mode_a: assert property (i2c_transmit_i_unused_o |-> i2c_mode_o)
    else $error("hold outside i2c");
endmodule // ssp_port_properties

/* tb/ssp_spi_peer.sv */
`timescale 1ns/1ps
// spi master peer, msb first, 800 ns link clock
module ssp_spi_peer (
  output logic sck_o,
  output logic sdi_o,
  output logic sel_n_o,
  input wire logic sdo_i
);
  // idle link
  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b0;
    sel_n_o = 1'b1;
  end
  // one byte; clock still outside the frame
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    #30 sel_n_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sdi_o = tx[i];
      #400 sck_o = 1'b1;
      rx[i] = sdo_i;
      #400 sck_o = 1'b0;
    end
    sdi_o = ~tx[0]; // released line inverted
    sel_n_o = 1'b1;
  endtask
endmodule // ssp_spi_peer

/* tb/ssp_port_bench.sv */
`timescale 1ns/1ps
`include "ssp_consts.vh"
module ssp_port_bench;
  logic clock_i, nrst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, b1, b2, got;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic sck_pin_i, sck_pin_o, sck_pin_oe_o, sdi_pin_i, sdo_pin_o, sdo_pin_oe_o, sel_n_pin_i;
  logic port_owns_pins_o, i2c_mode_o, i2c_transmit_i_unused_o;
  logic [16:0] seed = 17'h115E8;
  logic [3:0] codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hB, 4'hE, 4'hF};
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  ssp_port dut (.*);
  ssp_spi_peer peer (.sck_o(sck_pin_i), .sdi_o(sdi_pin_i), .sel_n_o(sel_n_pin_i), .sdo_i(sdo_pin_o));
  ////////////////////////////////////////
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  function automatic logic is_i2c(input logic [3:0] m);
    return m inside {4'h6, 4'h7, 4'hB, 4'hE, 4'hF};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // bus write, each channel released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clock_i);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clock_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end while (!tb);
  endtask
  // bus read
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clock_i);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock_i);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end while (!tr);
  endtask
  task wrap_up;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // clock and hang guard
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  ////////////////////////////////////////
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    nrst_i = 1'b0;
    repeat (8) @(posedge clock_i);
    nrst_i <= 1'b1;
    rd(`SSP_ADDR_CTRL);
    chk("ctrl reset", v, 32'h00);
    rd(8'h40);
    chk("unmapped", r, `SSP_RESP_SLVERR);
    wr(8'h40, 8'h00);
    chk("unmapped wr", r, `SSP_RESP_SLVERR);
    // every mode code, random hold bit
    foreach (codes[i]) begin
      seed = lfsr(seed);
      wr(`SSP_ADDR_CTRL, {3'b001, seed[0], codes[i]});
      chk("ctrl wr", r, `SSP_RESP_OKAY);
      @(negedge clock_i);
      if (codes[i] < 4'h4) chk("master idle", sck_pin_o, seed[0]);
      chk("i2c mode", i2c_mode_o, is_i2c(codes[i]));
      chk("sck oe", sck_pin_oe_o, codes[i] < 4'h4);
      chk("sdo oe", sdo_pin_oe_o, codes[i] < 4'h4 || codes[i] == 4'h5);
      chk("hold", i2c_transmit_i_unused_o, codes[i][3:1] == 3'h3 && !seed[0]);
      wr(`SSP_ADDR_CTRL, 8'h00);
      chk("pins back", port_owns_pins_o, 1'b0);
    end
    // slave: transfer, overflow, collision
    b1 = seed[7:0];
    b2 = ~seed[15:8];
    wr(`SSP_ADDR_CTRL, 8'h25);
    wr(`SSP_ADDR_BUF, b2);
    peer.xfer(b1, got);
    chk("slave tx", got, b2);
    rd(`SSP_ADDR_BUF);
    chk("slave rx", v, b1);
    peer.xfer(b1, got);
    peer.xfer(b2, got);
    rd(`SSP_ADDR_CTRL);
    chk("overflow", v, 32'h65);
    rd(`SSP_ADDR_BUF);
    chk("kept byte", v, b1);
    // word loaded first so the frame is shifting it out when the next write lands
    wr(`SSP_ADDR_BUF, b2);
    fork
      peer.xfer(b2, got);
      begin
        repeat (20) @(posedge clock_i);
        wr(`SSP_ADDR_BUF, b1);
      end
    join
    rd(`SSP_ADDR_CTRL);
    chk("collision", v, 32'hE5);
    wr(`SSP_ADDR_CTRL, 8'h25);
    rd(`SSP_ADDR_CTRL);
    chk("cleared", v, 32'h25);
    // master with full buffer
    wr(`SSP_ADDR_CTRL, 8'h00);
    wr(`SSP_ADDR_CTRL, 8'h20);
    repeat (2) begin
      seed = lfsr(seed);
      wr(`SSP_ADDR_BUF, seed[7:0]);
      do rd(`SSP_ADDR_STAT); while (v[1]);
    end
    chk("sck idle", sck_pin_o, 1'b0);
    rd(`SSP_ADDR_CTRL);
    chk("master ovf", v, 32'h20);
    // idle data line is the inverse of the peer's last bit; full buffer still reloads
    rd(`SSP_ADDR_BUF);
    chk("master rx", v, {24'h000000, {8{~b2[0]}}});
    wrap_up();
  end
endmodule // ssp_port_bench
bind ssp_port ssp_port_properties props (.*);
